/* File: byte_op_decoder_pkg.sv */
// Constants, operation codes and carriers for the byte-op instruction decoder.
// Assumes one 250 MHz clock; registers reached over AHB-Lite.
package byte_op_decoder_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  BANK_OFS        = 8'h04;
  localparam logic [7:0]  STATUS_OFS      = 8'h08;
  localparam logic [7:0]  COUNT_OFS       = 8'h0C;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_PRESC_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h1;
  localparam logic [3:0]  BANK_RESET      = 4'h0;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;

  // ==========================================================
  // Addresses and encodings
  localparam logic [3:0]  ACCESS_BANK     = 4'h0;
  localparam logic [11:0] TIMER_ADDR      = 12'hF00;
  localparam logic [11:0] PORT_LO_ADDR    = 12'hF80;
  localparam logic [11:0] PORT_HI_ADDR    = 12'hF8F;
  localparam logic [3:0]  SECOND_PREFIX   = 4'hF;
  localparam logic [3:0]  MOVE_PREFIX     = 4'hC;

  // ==========================================================
  // Status flag masks: {N, OV, Z, DC, C}
  localparam logic [4:0]  FL_NONE         = 5'h00;
  localparam logic [4:0]  FL_ALL          = 5'h1F;
  localparam logic [4:0]  FL_ZN           = 5'h14;
  localparam logic [4:0]  FL_CZN          = 5'h15;
  localparam logic [4:0]  FL_Z            = 5'h04;

  // ==========================================================
  // Operations
  typedef enum logic [5:0] {
    OP_NOP, add_acc_file, add_acc_file_carry, and_acc_file, or_acc_file,
    xor_acc_file, complement_file, move_file, clear_file, set_file_ones,
    store_acc_to_file, negate_file, multiply_acc_file, compare_skip_equal,
    compare_skip_greater, compare_skip_less, test_skip_zero, decrement_file,
    increment_file, decrement_skip_zero, decrement_skip_nonzero,
    increment_skip_zero, increment_skip_nonzero, rotate_left_carry,
    rotate_right_carry, rotate_left_plain, rotate_right_plain,
    nibble_swap_file, sub_file_from_acc_borrow, sub_acc_from_file,
    sub_acc_from_file_borrow, file_to_file_move, absolute_jump, OP_CALL,
    relative_branch_always, OP_BRANCH_COND, bit_set_file, OP_BIT_CLEAR,
    OP_BIT_TOGGLE, OP_BIT_SKIP_SET, OP_BIT_SKIP_CLEAR, OP_ADD_LIT,
    OP_AND_LIT, OP_OR_LIT
  } op_t;

  typedef enum logic [2:0] {
    ST_FIRST = 3'h1,
    ST_MOVE2 = 3'h2,
    ST_JUMP2 = 3'h4
  } word_state_t;

  typedef struct packed {
    op_t         op;
    logic        wr_acc;
    logic        wr_file;
    logic        banked;
    logic        skip_op;
    logic        cond_op;
    logic        pc_change;
    logic        two_word;
    logic        fast;
    logic        wr_product;
    logic        use_pins;
    logic        clr_prescaler;
    logic [4:0]  flags;
    logic [2:0]  bit_pos;
    logic [2:0]  cond_sel;
    logic [7:0]  literal;
    logic [11:0] file_addr;
    logic [11:0] dest_addr;
    logic [10:0] offset;
    logic [19:0] target;
  } dec_t;

endpackage

/* File: byte_op_instruction_decoder.sv */
// Instruction decoder for 16-bit program words, with its AHB-Lite registers.
// Assumes fetch presents one word per instr_valid and the datapath drives
// cond_true in the cycle that a skip or conditional branch is shown.
module byte_op_instruction_decoder
  import byte_op_decoder_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Instruction fetch
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  // Datapath feedback
  input  wire logic        cond_true,
  // Decoded operation
  output dec_t             dec_out,
  output logic             dec_valid,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  // ==========================================================
  // First-word decode
  function automatic dec_t decode_first(input logic [15:0] w);
    dec_t d;
    d = '0;
    d.op = OP_NOP;
    d.wr_file = w[9];
    d.wr_acc = ~w[9];
    d.banked = w[8];
    d.file_addr = {4'h0, w[7:0]};
    d.bit_pos = w[11:9];
    d.literal = w[7:0];
    d.cond_sel = w[10:8];
    d.target = {12'h000, w[7:0]};
    d.offset = {{3{w[7]}}, w[7:0]};
    casez (w[15:9])
      7'b0000001: begin
        d.op = multiply_acc_file;
        d.wr_product = 1'b1;
        d.wr_file = 1'b0;
        d.wr_acc = 1'b0;
      end
      7'b000001?: begin
        d.op = decrement_file;
        d.flags = FL_ALL;
      end
      7'b00001??: begin
        d.wr_file = 1'b0;
        d.wr_acc = 1'b1;
        d.banked = 1'b0;
        case (w[11:8])
          4'hF: begin
            d.op = OP_ADD_LIT;
            d.flags = FL_ALL;
          end
          4'hB: begin
            d.op = OP_AND_LIT;
            d.flags = FL_ZN;
          end
          4'h9: begin
            d.op = OP_OR_LIT;
            d.flags = FL_ZN;
          end
          default: begin
            d.wr_acc = 1'b0;
          end
        endcase
      end
      7'b000100?: begin
        d.op = or_acc_file;
        d.flags = FL_ZN;
      end
      7'b000101?: begin
        d.op = and_acc_file;
        d.flags = FL_ZN;
      end
      7'b000110?: begin
        d.op = xor_acc_file;
        d.flags = FL_ZN;
      end
      7'b000111?: begin
        d.op = complement_file;
        d.flags = FL_ZN;
      end
      7'b001000?: begin
        d.op = add_acc_file_carry;
        d.flags = FL_ALL;
      end
      7'b001001?: begin
        d.op = add_acc_file;
        d.flags = FL_ALL;
      end
      7'b001010?: begin
        d.op = increment_file;
        d.flags = FL_ALL;
      end
      7'b001011?: begin
        d.op = decrement_skip_zero;
        d.skip_op = 1'b1;
      end
      7'b001100?: begin
        d.op = rotate_right_carry;
        d.flags = FL_CZN;
      end
      7'b001101?: begin
        d.op = rotate_left_carry;
        d.flags = FL_CZN;
      end
      7'b001110?: d.op = nibble_swap_file;
      7'b001111?: begin
        d.op = increment_skip_zero;
        d.skip_op = 1'b1;
      end
      7'b010000?: begin
        d.op = rotate_right_plain;
        d.flags = FL_ZN;
      end
      7'b010001?: begin
        d.op = rotate_left_plain;
        d.flags = FL_ZN;
      end
      7'b010010?: begin
        d.op = increment_skip_nonzero;
        d.skip_op = 1'b1;
      end
      7'b010011?: begin
        d.op = decrement_skip_nonzero;
        d.skip_op = 1'b1;
      end
      7'b010100?: begin
        d.op = move_file;
        d.flags = FL_ZN;
      end
      7'b010101?: begin
        d.op = sub_file_from_acc_borrow;
        d.flags = FL_ALL;
      end
      7'b010110?: begin
        d.op = sub_acc_from_file_borrow;
        d.flags = FL_ALL;
      end
      7'b010111?: begin
        d.op = sub_acc_from_file;
        d.flags = FL_ALL;
      end
      7'b0110???: begin
        d.wr_acc = 1'b0;
        d.wr_file = w[11];
        d.skip_op = ~w[11];
        case (w[11:9])
          3'h0: d.op = compare_skip_less;
          3'h1: d.op = compare_skip_equal;
          3'h2: d.op = compare_skip_greater;
          3'h3: d.op = test_skip_zero;
          3'h4: d.op = set_file_ones;
          3'h5: begin
            d.op = clear_file;
            d.flags = FL_Z;
          end
          3'h6: begin
            d.op = negate_file;
            d.flags = FL_ALL;
          end
          default: d.op = store_acc_to_file;
        endcase
      end
      7'b0111???, 7'b10?????: begin
        d.wr_acc = 1'b0;
        d.wr_file = ~(w[15] & w[13]);
        d.skip_op = w[15] & w[13];
        case (w[14:12])
          3'h0: d.op = bit_set_file;
          3'h1: d.op = OP_BIT_CLEAR;
          3'h2: d.op = OP_BIT_SKIP_SET;
          3'h3: d.op = OP_BIT_SKIP_CLEAR;
          default: d.op = OP_BIT_TOGGLE;
        endcase
      end
      7'b1100???: begin
        d.op = file_to_file_move;
        d.file_addr = w[11:0];
        d.banked = 1'b0;
        d.wr_acc = 1'b0;
        d.wr_file = 1'b0;
        d.two_word = 1'b1;
      end
      7'b11010??: begin
        d.op = relative_branch_always;
        d.offset = w[10:0];
        d.pc_change = 1'b1;
        d.wr_acc = 1'b0;
        d.wr_file = 1'b0;
        d.banked = 1'b0;
      end
      7'b11100??: begin
        d.op = OP_BRANCH_COND;
        d.cond_op = 1'b1;
        d.wr_acc = 1'b0;
        d.wr_file = 1'b0;
        d.banked = 1'b0;
      end
      7'b1110110, 7'b1110111: begin
        d.op = w[9] ? (w[8] ? absolute_jump : OP_NOP) : OP_CALL;
        d.fast = ~w[9] & w[8];
        d.two_word = ~w[9] | w[8];
        d.pc_change = ~w[9] | w[8];
        d.wr_acc = 1'b0;
        d.wr_file = 1'b0;
        d.banked = 1'b0;
      end
      default: begin
        d.wr_acc = 1'b0;
        d.wr_file = 1'b0;
        d.banked = 1'b0;
      end
    endcase
    return d;
  endfunction

  // ==========================================================
  // Registers and state
  logic [1:0]  ctrl;
  logic [3:0]  bank_select_reg;
  logic [15:0] count;
  word_state_t state;
  dec_t        hold;
  logic        kill_pend;
  logic        wr_pend;
  logic [7:0]  wr_ofs;

  word_state_t next_state;
  dec_t        next_dec;
  dec_t        next_hold;
  logic        next_valid;

  // ==========================================================
  // Address forming and side effects
  dec_t        first_raw;
  dec_t        first_full;
  logic [11:0] eff_addr;
  logic        port_hit;
  logic        rmw_op;
  logic        kill;
  logic        second_ok;
  logic        decode_en;
  logic        presc_assigned;

  assign first_raw = decode_first(instr_word);
  assign eff_addr = first_raw.banked ? {bank_select_reg, first_raw.file_addr[7:0]}
                                     : (first_raw.two_word ? first_raw.file_addr
                                        : {ACCESS_BANK, first_raw.file_addr[7:0]});
  assign port_hit = (eff_addr >= PORT_LO_ADDR) && (eff_addr <= PORT_HI_ADDR);
  assign rmw_op = (first_raw.op != clear_file) && (first_raw.op != set_file_ones)
                  && (first_raw.op != store_acc_to_file);
  assign decode_en = ctrl[CTRL_EN_BIT];
  assign presc_assigned = ctrl[CTRL_PRESC_BIT];
  assign second_ok = (instr_word[15:12] == SECOND_PREFIX);
  assign kill = kill_pend || (dec_valid && (dec_out.pc_change
                || ((dec_out.skip_op || dec_out.cond_op) && cond_true)));

  always_comb begin
    first_full = first_raw;
    first_full.file_addr = eff_addr;
    first_full.use_pins = first_raw.wr_file && rmw_op && port_hit;
    first_full.clr_prescaler = first_raw.wr_file && presc_assigned
                               && (eff_addr == TIMER_ADDR);
  end

  // ==========================================================
  // Word sequencing
  always_comb begin
    next_state = state;
    next_dec = dec_out;
    next_hold = hold;
    next_valid = 1'b0;
    if (instr_valid) begin
      case (state)
        ST_FIRST: begin
          if (kill || !decode_en) begin
            next_dec = '0;
            next_valid = 1'b1;
          end else if (first_full.two_word) begin
            next_hold = first_full;
            next_state = (first_full.op == file_to_file_move) ? ST_MOVE2 : ST_JUMP2;
          end else begin
            next_dec = first_full;
            next_valid = 1'b1;
          end
        end
        ST_MOVE2: begin
          next_dec = '0;
          if (second_ok) begin
            next_dec = hold;
            next_dec.dest_addr = instr_word[11:0];
            next_dec.wr_file = 1'b1;
            next_dec.clr_prescaler = presc_assigned && (instr_word[11:0] == TIMER_ADDR);
          end
          next_valid = 1'b1;
          next_state = ST_FIRST;
        end
        ST_JUMP2: begin
          next_dec = '0;
          if (second_ok) begin
            next_dec = hold;
            next_dec.target = {instr_word[11:0], hold.target[7:0]};
          end
          next_valid = 1'b1;
          next_state = ST_FIRST;
        end
        default: next_state = ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_FIRST;
      dec_out <= '0;
      hold <= '0;
      dec_valid <= 1'b0;
      kill_pend <= 1'b0;
      count <= COUNT_RESET;
    end else begin
      state <= next_state;
      dec_out <= next_dec;
      hold <= next_hold;
      dec_valid <= next_valid;
      kill_pend <= kill && !(instr_valid && state == ST_FIRST);
      count <= next_valid ? count + 16'h0001 : count;
    end
  end

  // ==========================================================
  // AHB-Lite register slave
  logic        bus_take;
  logic [31:0] rd_mux;

  assign bus_take = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_mux = (haddr[7:0] == CTRL_OFS)   ? {30'h0, ctrl} :
                  (haddr[7:0] == BANK_OFS)   ? {28'h0, bank_select_reg} :
                  (haddr[7:0] == STATUS_OFS) ? {18'h0, dec_out.op, 4'h0, kill_pend, state} :
                  (haddr[7:0] == COUNT_OFS)  ? {16'h0, count} : 32'h0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pend <= bus_take && hwrite;
      wr_ofs <= haddr[7:0];
      hrdata <= (bus_take && !hwrite) ? rd_mux : hrdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      bank_select_reg <= BANK_RESET;
    end else if (wr_pend) begin
      ctrl <= (wr_ofs == CTRL_OFS) ? hwdata[1:0] : ctrl;
      bank_select_reg <= (wr_ofs == BANK_OFS) ? hwdata[3:0] : bank_select_reg;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_dest_select: assert property (
    instr_valid && state == ST_FIRST && !kill && decode_en && instr_word[15:12] == 4'h2
    |=> dec_valid && dec_out.wr_file == $past(instr_word[9])
        && dec_out.wr_acc == !$past(instr_word[9]))
    else $error("destination bit not honoured");

  chk_bank_addr: assert property (
    instr_valid && state == ST_FIRST && !kill && decode_en && instr_word[15:10] == 6'h09
    |=> dec_out.file_addr == ($past(instr_word[8]) ? {$past(bank_select_reg),
        $past(instr_word[7:0])} : {ACCESS_BANK, $past(instr_word[7:0])}))
    else $error("bank address wrong");

  chk_move_hold: assert property (
    instr_valid && state == ST_FIRST && !kill && decode_en && instr_word[15:12] == MOVE_PREFIX
    |=> !dec_valid && state == ST_MOVE2)
    else $error("move first word not held");

  chk_move_pair: assert property (
    instr_valid && state == ST_MOVE2 && second_ok
    |=> dec_valid && dec_out.op == file_to_file_move
        && dec_out.dest_addr == $past(instr_word[11:0]))
    else $error("move pair wrong");

  chk_jump_target: assert property (
    instr_valid && state == ST_JUMP2 && second_ok
    |=> dec_valid && dec_out.target == {$past(instr_word[11:0]), $past(hold.target[7:0])})
    else $error("jump target wrong");

  chk_taken_nop: assert property (
    dec_valid && (dec_out.pc_change || (dec_out.skip_op && cond_true))
    && instr_valid && state == ST_FIRST
    |=> dec_valid && dec_out.op == OP_NOP && !dec_out.wr_file)
    else $error("taken flow not followed by nop");

  chk_lone_second: assert property (
    instr_valid && state == ST_FIRST && second_ok
    |=> dec_valid && dec_out.op == OP_NOP && !dec_out.wr_acc && !dec_out.wr_file)
    else $error("lone second word not nop");

  chk_mul_product: assert property (
    dec_valid && dec_out.op == multiply_acc_file
    |-> dec_out.flags == FL_NONE && dec_out.wr_product && !dec_out.wr_file)
    else $error("multiply decode wrong");

  chk_prescaler: assert property (
    dec_valid && dec_out.clr_prescaler |-> $past(presc_assigned) && dec_out.wr_file)
    else $error("prescaler clear without cause");

endmodule

/* File: fetch_model.sv */
// Instruction fetch model: presents one program word per bench request.
// Assumes the bench raises fetch_req for one clock per word.
module fetch_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Bench side
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_word,
  // Decoder side
  output logic             instr_valid,
  output logic [15:0]      instr_word
);
  // ==========================================================
  // Word presentation
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      instr_valid <= 1'b0;
      instr_word  <= 16'hA5A5;
    end else if (fetch_req) begin
      instr_valid <= 1'b1;
      instr_word  <= fetch_word;
    end else begin
      // Idle word changes every cycle
      instr_valid <= 1'b0;
      instr_word  <= {~instr_word[0], instr_word[15:1]};
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench for the byte-op instruction decoder.
// Assumes zero-wait AHB-Lite slave and registered decode one cycle late.
module tb
  import byte_op_decoder_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic        sys_clk, rst, fetch_req, cond_true, instr_valid, dec_valid;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [15:0] fetch_word, instr_word;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  dec_t        dec_out;
  int          mismatches, compares;

  // ==========================================================
  // Byte-op table
  localparam int NB = 30;
  logic [7:0]  th  [NB] = '{8'h26, 8'h22, 8'h16, 8'h12, 8'h1A, 8'h1E, 8'h52, 8'h6A,
    8'h68, 8'h6E, 8'h6C, 8'h02, 8'h62, 8'h64, 8'h60, 8'h66, 8'h06, 8'h2A, 8'h2E, 8'h4E,
    8'h3E, 8'h4A, 8'h36, 8'h32, 8'h46, 8'h42, 8'h3A, 8'h56, 8'h5E, 8'h5A};
  op_t         top [NB] = '{add_acc_file, add_acc_file_carry, and_acc_file, or_acc_file,
    xor_acc_file, complement_file, move_file, clear_file, set_file_ones, store_acc_to_file,
    negate_file, multiply_acc_file, compare_skip_equal, compare_skip_greater,
    compare_skip_less, test_skip_zero, decrement_file, increment_file, decrement_skip_zero,
    decrement_skip_nonzero, increment_skip_zero, increment_skip_nonzero, rotate_left_carry,
    rotate_right_carry, rotate_left_plain, rotate_right_plain, nibble_swap_file,
    sub_file_from_acc_borrow, sub_acc_from_file, sub_acc_from_file_borrow};
  logic [4:0]  tfl [NB] = '{FL_ALL, FL_ALL, FL_ZN, FL_ZN, FL_ZN, FL_ZN, FL_ZN, FL_Z,
    FL_NONE, FL_NONE, FL_ALL, FL_NONE, FL_NONE, FL_NONE, FL_NONE, FL_NONE, FL_ALL, FL_ALL,
    FL_NONE, FL_NONE, FL_NONE, FL_NONE, FL_CZN, FL_CZN, FL_ZN, FL_ZN, FL_NONE, FL_ALL,
    FL_ALL, FL_ALL};

  // ==========================================================
  // Instances
  fetch_model fetch_model_inst (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .fetch_req   (fetch_req),
    .fetch_word  (fetch_word),
    .instr_valid (instr_valid),
    .instr_word  (instr_word)
  );

  byte_op_instruction_decoder byte_op_instruction_decoder_inst (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .instr_valid (instr_valid),
    .instr_word  (instr_word),
    .cond_true   (cond_true),
    .dec_out     (dec_out),
    .dec_valid   (dec_valid),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hreadyout),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .hrdata      (hrdata)
  );

  // ==========================================================
  // Compare tasks
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check_op(input op_t exp);
    compares++;
    if (dec_out.op !== exp) begin
      mismatches++;
      $display("unexpected at %0t: op %0d, wanted %0d", $time, dec_out.op, exp);
    end
  endtask

  // ==========================================================
  // Bus tasks
  task automatic bus(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rdata = hrdata;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    bus(addr, 1'b1, data, d);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    bus(addr, 1'b0, 32'h0, d);
    check_val(d, exp);
    check_val(32'(hresp), 32'h0);
  endtask

  // ==========================================================
  // Instruction tasks
  task automatic send(input logic [15:0] w);
    @(posedge sys_clk);
    fetch_req  <= 1'b1;
    fetch_word <= w;
    @(posedge sys_clk);
    fetch_req <= 1'b0;
  endtask

  task automatic wait_dec;
    int n;
    n = 0;
    compares++;
    do begin
      @(negedge sys_clk);
      n++;
    end while (dec_valid !== 1'b1 && n < 8);
    if (dec_valid !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no decode", $time);
    end
  endtask

  task automatic dec1(input logic [15:0] w);
    send(w);
    wait_dec();
  endtask

  task automatic dec2(input logic [15:0] a, input logic [15:0] b);
    @(posedge sys_clk);
    fetch_req  <= 1'b1;
    fetch_word <= a;
    @(posedge sys_clk);
    fetch_word <= b;
    @(posedge sys_clk);
    fetch_req <= 1'b0;
    wait_dec();
  endtask

  task automatic final_report;
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #20000;
    mismatches++;
    final_report();
  end

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    fetch_req = 1'b0;
    fetch_word = 16'h0;
    cond_true = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mismatches = 0;
    compares = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(CTRL_OFS, 32'(CTRL_RESET));
    rd_chk(BANK_OFS, 32'(BANK_RESET));
    rd_chk(COUNT_OFS, 32'(COUNT_RESET));
    rd_chk(STATUS_OFS, 32'h1);
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0);
    for (int i = 0; i < NB; i++) begin
      dec1({th[i], 8'(i + 64)});
      check_op(top[i]);
      check_val(32'(dec_out.flags), 32'(tfl[i]));
      check_val(32'(dec_out.file_addr), {20'h0, ACCESS_BANK, 8'(i + 64)});
      check_val(32'(dec_out.wr_product), 32'(top[i] == multiply_acc_file));
    end
    for (int d = 0; d < 2; d++) begin
      dec1({6'h09, d[0], 9'h021});
      check_val({30'h0, dec_out.wr_acc, dec_out.wr_file}, d ? 32'h1 : 32'h2);
    end
    wr(BANK_OFS, 32'h5);
    rd_chk(BANK_OFS, 32'h5);
    dec1(16'h2721);
    check_val(32'(dec_out.banked), 32'h1);
    check_val(32'(dec_out.file_addr), 32'h521);
    wr(BANK_OFS, 32'hF);
    dec1(16'h5385);
    check_val({19'h0, dec_out.use_pins, dec_out.file_addr}, 32'h1F85);
    wr(CTRL_OFS, 32'h3);
    dec1(16'h6B00);
    check_val(32'(dec_out.clr_prescaler), 32'h1);
    wr(CTRL_OFS, 32'h1);
    dec1(16'h6B00);
    check_val(32'(dec_out.clr_prescaler), 32'h0);
    dec2(16'hC123, 16'hF456);
    check_op(file_to_file_move);
    check_val({8'h0, dec_out.file_addr, dec_out.dest_addr}, 32'h123456);
    dec1(16'h8A21);
    check_op(bit_set_file);
    check_val(32'(dec_out.bit_pos), 32'h5);
    dec1(16'h0F7F);
    check_val(32'(dec_out.literal), 32'h7F);
    dec1(16'hE280);
    check_val(32'(dec_out.offset), 32'h780);
    dec1(16'hD3FF);
    check_val({20'h0, dec_out.pc_change, dec_out.offset}, 32'hBFF);
    dec1(16'h2621);
    check_op(OP_NOP);
    dec2(16'hD3FF, 16'h2621);
    check_op(relative_branch_always);
    wait_dec();
    check_op(OP_NOP);
    dec2(16'hEF34, 16'hF567);
    check_val(32'(dec_out.target), 32'h56734);
    dec1(16'h2621);
    check_op(OP_NOP);
    for (int s = 0; s < 2; s++) begin
      dec2({7'h76, s[0], 8'h12}, 16'hFABC);
      check_op(OP_CALL);
      check_val({11'h0, dec_out.fast, dec_out.target}, {11'h0, s[0], 20'hABC12});
      dec1(16'h2621);
      check_op(OP_NOP);
    end
    @(posedge sys_clk);
    cond_true <= 1'b1;
    dec1(16'h6221);
    check_op(compare_skip_equal);
    check_val(32'(dec_out.skip_op), 32'h1);
    @(posedge sys_clk);
    cond_true <= 1'b0;
    dec1(16'h2621);
    check_op(OP_NOP);
    dec1(16'hF123);
    check_op(OP_NOP);
    dec1(16'h0004);
    check_op(OP_NOP);
    check_val({25'h0, dec_out.wr_acc, dec_out.wr_file, dec_out.flags}, 32'h0);
    wr(CTRL_OFS, 32'h0);
    dec1(16'h2621);
    check_op(OP_NOP);
    rd_chk(COUNT_OFS, 32'h37);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(CTRL_OFS, 32'(CTRL_RESET));
    rd_chk(STATUS_OFS, 32'h1);
    rd_chk(COUNT_OFS, 32'(COUNT_RESET));
    final_report();
  end
endmodule
